/* common/energy_accum_map.vh */
// register offsets, field positions, reset values and timing counts
// for the per-phase energy and power accumulation block.
// assumes a 32-bit AHB-Lite register port, byte addresses below.
`ifndef ENERGY_ACCUM_MAP_VH
`define ENERGY_ACCUM_MAP_VH

// register byte offsets
`define OFS_EP_CONFIG      12'h000
`define OFS_ENERGY_TIME    12'h004
`define OFS_POWER_TIME     12'h008
`define OFS_ACC_MODE       12'h00C
`define OFS_ACT_THR        12'h010
`define OFS_REACT_THR      12'h014
`define OFS_APP_THR        12'h018
`define OFS_NOLOAD_FLAGS   12'h01C
`define OFS_STATUS         12'h020
`define OFS_IRQ_ENABLE     12'h024
`define OFS_ENERGY_BASE    12'h100
`define OFS_POWER_BASE     12'h200

// energy_power_config fields
`define CFG_RUN_BIT        0
`define CFG_LD_ACCUM_BIT   1
`define CFG_TMR_MODE_BIT   2
`define CFG_NL_SEL_LSB     4
`define CFG_EVENT_SEL_BIT  8

// accumulation_mode_reg fields
`define MODE_ACT_LSB       0
`define MODE_REACT_LSB     2
`define MODE_FREQ_BIT      4

// reset values
`define RST_NL_SEL         3'h0
`define RST_ENERGY_TIME    13'h0000
`define RST_POWER_TIME     13'h1FFF
`define RST_THRESHOLD      32'h00006778

// codes and counts
`define NL_DISABLED        3'h7
`define NL_BASE_WINDOW     13'h0040
`define PF_LAST_SAMPLE     12'hFFF
`define HALF_CYC_50HZ      5'h13
`define HALF_CYC_60HZ      5'h17
`define NUM_CHAN           5'h12
`define STATUS_PHASE_B     3
`define NL_FUND_LSB        16

`endif

/* rtl/chan_state_ram.v */
// per-channel internal accumulator storage, one word per channel.
// assumes one write and one read per cycle; read data is registered.
`timescale 1ns/1ps
module chan_state_ram #(
   parameter WIDTH = 131,
   parameter DEPTH = 18,
   parameter AW    = 5
)(
   // clock and freeze
   input  wire             hclk,
   input  wire             ce,
   // write port
   input  wire             wr_en,
   input  wire [AW-1:0]    wr_addr,
   input  wire [WIDTH-1:0] wr_data,
   // read port
   input  wire [AW-1:0]    rd_addr,
   output reg  [WIDTH-1:0] rd_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];   // storage, no reset on purpose

   // contents are never reset: the sequencer masks the first pass
   always @(posedge hclk)
   begin
      if (ce)
      begin
         if (wr_en)
            mem[wr_addr] <= wr_data;
         rd_data <= mem[rd_addr];
      end
   end
endmodule // chan_state_ram

/* rtl/energy_accum_noload.v */
// per-phase energy and power accumulation with no-load detection.
// assumes samples arrive with sample_strobe at the DSP rate, far
// slower than the 18-cycle-pair channel sweep, and an AHB-Lite master.
`timescale 1ns/1ps
`include "energy_accum_map.vh"
module energy_accum_noload (
   // clock, freeze and reset
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        ce,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [11:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // power samples, phase a in bits 31:0, b 63:32, c 95:64
   input  wire        sample_strobe,
   input  wire        half_cycle_pulse,
   input  wire [95:0] active_power,
   input  wire [95:0] reactive_power,
   input  wire [95:0] apparent_power,
   input  wire [95:0] fund_active_power,
   input  wire [95:0] fund_reactive_power,
   input  wire [95:0] fund_apparent_power,
   // events
   output reg         interrupt_out,
   output reg         event_n,
   output reg         pf_update,
   output reg         rms_half_update,
   output reg         rms_multi_update
);
   localparam S_IDLE = 2'h0;          // waiting for a sample
   localparam S_READ = 2'h1;          // state word address issued
   localparam S_CALC = 2'h2;          // state word present, update

   ////////////////////////////////////////////////////////////////////
   // functions
   // apply an accumulation mode to a sample, result 33-bit signed
   function [32:0] gate_sample;
      input [31:0] p;
      input [1:0]  mode;
      reg   [32:0] s;
      begin
         s = {p[31], p};
         case (mode)
            2'h0: gate_sample = s;
            2'h1: gate_sample = p[31] ? (33'h0 - s) : s;
            2'h2: gate_sample = p[31] ? 33'h0 : s;
            default: gate_sample = p[31] ? s : 33'h0;
         endcase
      end
   endfunction

   // energy group of a type: 0 active, 1 reactive, 2 apparent
   function [1:0] group_of;
      input [2:0] ty;
      begin
         group_of = (ty >= 3'h3) ? (ty[1:0] - 2'h3) : ty[1:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // software registers
   reg        run_en;                 // accum_run_enable
   reg        ld_accum;               // overwrite instead of add
   reg        tmr_mode;               // 1: half line cycle timing
   reg [2:0]  noload_window_sel;      // window code
   reg        event_sel;              // no-load onto event pin
   reg [12:0] energy_interval_count;  // samples or half cycles - 1
   reg [12:0] power_interval_count;   // samples - 1
   reg [1:0]  active_accum_mode;      // active treatment
   reg [1:0]  reactive_accum_mode;    // reactive treatment
   reg        line_freq_select;       // 0: 50 hz, 1: 60 hz
   reg [31:0] thr [0:2];              // no-load thresholds
   reg [5:0]  status;                 // sticky no-load changes
   reg [5:0]  irq_en;                 // interrupt enables
   reg [17:0] nl_flag;                // no-load flag per channel
   reg [44:0] user_energy [0:17];     // user energy registers
   reg [44:0] power_sum [0:17];       // power accumulation results

   // bus pipeline
   reg        wr_pend;                // write data phase pending
   reg [11:0] wr_addr;                // captured write address
   wire       addr_ok = hsel & htrans[1] & hready;

   // sequencer
   reg [1:0]  state;
   reg [4:0]  ch;                     // channel, type*3+phase
   reg [2:0]  ty;                     // energy type 0..5
   reg [1:0]  ph;                     // phase 0..2
   reg        first_pass;             // stored words not yet valid
   reg        egy_rdy;                // energy-ready this sweep
   reg        pwr_rdy;                // power interval end this sweep
   reg        nl_end;                 // no-load window end this sweep
   reg [12:0] egy_cnt;                // energy interval counter
   reg [12:0] zx_cnt;                 // half cycle counter
   reg        zx_pend;                // half cycle interval reached
   reg [12:0] pwr_cnt;                // power interval counter
   reg [12:0] nl_cnt;                 // no-load window counter
   reg [11:0] pf_cnt;                 // power factor block counter
   reg [4:0]  hc_cnt;                 // half cycles for multi rms
   reg [95:0] smp [0:5];              // captured samples per type
   reg [5:0]  chg;                    // changes seen in this sweep

   ////////////////////////////////////////////////////////////////////
   // channel datapath
   wire [130:0] rd_word;
   wire [31:0]  p = smp[ty][ph*32 +: 32];
   wire [1:0]   grp = group_of(ty);
   wire [1:0]   mode = (grp == 2'h0) ? active_accum_mode :
                       (grp == 2'h1) ? reactive_accum_mode :
                       2'h0;
   wire [32:0]  g = gate_sample(p, mode);
   wire         nl_off = (noload_window_sel == `NL_DISABLED);
   wire         nl_now = nl_flag[ch] & ~nl_off;
   wire [41:0]  iacc_old = first_pass ? 42'h0 : rd_word[41:0];
   wire [43:0]  nl_old = first_pass ? 44'h0 : rd_word[85:42];
   wire [44:0]  ps_old = first_pass ? 45'h0 : rd_word[130:86];
   // in no-load the energy path sees zero
   wire [41:0]  iacc_add = nl_now ? 42'h0 : {{9{g[32]}}, g};
   wire [41:0]  iacc_sum = iacc_old + iacc_add;
   wire [32:0]  pabs = gate_sample(p, 2'h1);
   wire [43:0]  nl_sum = nl_old + {11'h0, pabs};
   // window sum scaled back to a 64-sample basis
   wire [43:0]  nl_norm = nl_sum >> noload_window_sel;
   wire         below = (nl_norm < {12'h0, thr[grp]});
   wire [44:0]  ps_sum = ps_old + {{13{p[31]}}, p};
   wire [44:0]  iacc_ext = {{3{iacc_sum[41]}}, iacc_sum};
   wire [12:0]  nl_last = (`NL_BASE_WINDOW << noload_window_sel)
                          - 13'h0001;
   wire [130:0] wr_word = {pwr_rdy ? 45'h0 : ps_sum,
                           (nl_end | nl_off) ? 44'h0 : nl_sum,
                           egy_rdy ? 42'h0 : iacc_sum};
   wire         calc = (state == S_CALC);

   chan_state_ram #(
      .WIDTH (131),
      .DEPTH (18),
      .AW    (5)
   ) u_state (
      .hclk    (hclk),
      .ce      (ce),
      .wr_en   (calc),
      .wr_addr (ch),
      .wr_data (wr_word),
      .rd_addr (ch),
      .rd_data (rd_word)
   );

   ////////////////////////////////////////////////////////////////////
   // sweep sequencer: one read and one update per channel
   integer i;                         // sequencer reset loop
   integer j;                         // result array reset loop
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state <= S_IDLE;
         ch <= 5'h0;
         ty <= 3'h0;
         ph <= 2'h0;
         first_pass <= 1'b1;
         egy_rdy <= 1'b0;
         pwr_rdy <= 1'b0;
         nl_end <= 1'b0;
         egy_cnt <= 13'h0;
         pwr_cnt <= 13'h0;
         nl_cnt <= 13'h0;
         pf_cnt <= 12'h0;
         pf_update <= 1'b0;
         for (i = 0; i < 6; i = i + 1)
            smp[i] <= 96'h0;
      end
      else if (ce)
      begin
         pf_update <= 1'b0;
         case (state)
            S_IDLE:
            begin
               // run off restarts every interval count, so a new
               // start finishes no window begun before the stop, except a half cycle interval already pending in zx_pend
               if (!run_en)
               begin
                  first_pass <= 1'b1;
                  egy_cnt <= 13'h0;
                  pwr_cnt <= 13'h0;
                  nl_cnt <= 13'h0;
                  pf_cnt <= 12'h0;
               end
               // a new sample starts a sweep only while running
               if (sample_strobe && run_en)
               begin
                  smp[0] <= active_power;
                  smp[1] <= reactive_power;
                  smp[2] <= apparent_power;
                  smp[3] <= fund_active_power;
                  smp[4] <= fund_reactive_power;
                  smp[5] <= fund_apparent_power;
                  // energy-ready by samples or by half cycles
                  egy_rdy <= tmr_mode ? zx_pend
                             : (egy_cnt == energy_interval_count);
                  egy_cnt <= (egy_cnt == energy_interval_count)
                             ? 13'h0 : egy_cnt + 13'h0001;
                  pwr_rdy <= (pwr_cnt == power_interval_count);
                  pwr_cnt <= (pwr_cnt == power_interval_count)
                             ? 13'h0 : pwr_cnt + 13'h0001;
                  nl_end <= (nl_cnt == nl_last) & ~nl_off;
                  nl_cnt <= (nl_cnt == nl_last || nl_off)
                            ? 13'h0 : nl_cnt + 13'h0001;
                  pf_update <= (pf_cnt == `PF_LAST_SAMPLE);
                  pf_cnt <= pf_cnt + 12'h001;
                  ch <= 5'h0;
                  ty <= 3'h0;
                  ph <= 2'h0;
                  state <= S_READ;
               end
            end
            S_READ:
               state <= S_CALC;
            S_CALC:
            begin
               if (ch == `NUM_CHAN - 5'h01)
               begin
                  first_pass <= 1'b0;
                  state <= S_IDLE;
               end
               else
               begin
                  ch <= ch + 5'h01;
                  ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
                  ty <= (ph == 2'h2) ? ty + 3'h1 : ty;
                  state <= S_READ;
               end
            end
            default:
               state <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // result arrays, flags and change detection
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         nl_flag <= 18'h0;
         chg <= 6'h0;
         for (j = 0; j < 18; j = j + 1)
         begin
            user_energy[j] <= 45'h0;
            power_sum[j] <= 45'h0;
         end
      end
      else if (ce)
      begin
         if (state == S_IDLE)
            chg <= 6'h0;
         if (nl_off)
            nl_flag <= 18'h0;
         if (calc)
         begin
            // add to or overwrite the user register
            if (egy_rdy)
               user_energy[ch] <= ld_accum ? iacc_ext
                                  : user_energy[ch] + iacc_ext;
            if (pwr_rdy)
               power_sum[ch] <= ps_sum;
            if (nl_end)
            begin
               nl_flag[ch] <= below;
               if (nl_flag[ch] != below)
                  chg[ty] <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // line-cycle timing: half cycle energy interval and rms strobes
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         zx_cnt <= 13'h0;
         zx_pend <= 1'b0;
         hc_cnt <= 5'h0;
         rms_half_update <= 1'b0;
         rms_multi_update <= 1'b0;
      end
      else if (ce)
      begin
         rms_half_update <= half_cycle_pulse & run_en;
         rms_multi_update <= 1'b0;
         // consumed at the sample; a pulse in that cycle still sets
         if (sample_strobe && run_en && state == S_IDLE)
            zx_pend <= 1'b0;
         if (!run_en)
         begin
            zx_cnt <= 13'h0;
            hc_cnt <= 5'h0;
         end
         else if (half_cycle_pulse)
         begin
            if (zx_cnt == energy_interval_count)
            begin
               zx_cnt <= 13'h0;
               zx_pend <= 1'b1;
            end
            else
               zx_cnt <= zx_cnt + 13'h0001;
            if (hc_cnt == (line_freq_select ? `HALF_CYC_60HZ
                                            : `HALF_CYC_50HZ))
            begin
               hc_cnt <= 5'h0;
               rms_multi_update <= 1'b1;
            end
            else
               hc_cnt <= hc_cnt + 5'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // ahb-lite slave: zero wait states, read data set up in addr phase
   reg [31:0] rd_mux;
   reg [4:0]  rch;
   always @*
   begin
      rd_mux = 32'h0;
      rch = haddr[7:3];
      if (haddr == `OFS_EP_CONFIG)
         rd_mux = {23'h0, event_sel, 1'b0, noload_window_sel, 1'b0,
                   tmr_mode, ld_accum, run_en};
      else if (haddr == `OFS_ENERGY_TIME)
         rd_mux = {19'h0, energy_interval_count};
      else if (haddr == `OFS_POWER_TIME)
         rd_mux = {19'h0, power_interval_count};
      else if (haddr == `OFS_ACC_MODE)
         rd_mux = {27'h0, line_freq_select, reactive_accum_mode,
                   active_accum_mode};
      else if (haddr == `OFS_ACT_THR)
         rd_mux = thr[0];
      else if (haddr == `OFS_REACT_THR)
         rd_mux = thr[1];
      else if (haddr == `OFS_APP_THR)
         rd_mux = thr[2];
      else if (haddr == `OFS_NOLOAD_FLAGS)
         // per phase: apparent bit 2, reactive bit 1, active bit 0
         rd_mux = {7'h0,
                   nl_flag[17], nl_flag[14], nl_flag[11],
                   nl_flag[16], nl_flag[13], nl_flag[10],
                   nl_flag[15], nl_flag[12], nl_flag[9],
                   7'h0,
                   nl_flag[8], nl_flag[5], nl_flag[2],
                   nl_flag[7], nl_flag[4], nl_flag[1],
                   nl_flag[6], nl_flag[3], nl_flag[0]};
      else if (haddr == `OFS_STATUS)
         rd_mux = {26'h0, status};
      else if (haddr == `OFS_IRQ_ENABLE)
         rd_mux = {26'h0, irq_en};
      else if (haddr[11:8] == 4'h1 && rch < `NUM_CHAN)
         rd_mux = haddr[2] ? {19'h0, user_energy[rch][12:0]}
                           : user_energy[rch][44:13];
      else if (haddr[11:8] == 4'h2 && haddr[6:2] < `NUM_CHAN)
         rd_mux = power_sum[haddr[6:2]][44:13];
   end

   // register writes in the data phase; hardware set beats clear
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_addr <= 12'h0;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         run_en <= 1'b0;
         ld_accum <= 1'b0;
         tmr_mode <= 1'b0;
         noload_window_sel <= `RST_NL_SEL;
         event_sel <= 1'b0;
         energy_interval_count <= `RST_ENERGY_TIME;
         power_interval_count <= `RST_POWER_TIME;
         active_accum_mode <= 2'h0;
         reactive_accum_mode <= 2'h0;
         line_freq_select <= 1'b0;
         thr[0] <= `RST_THRESHOLD;
         thr[1] <= `RST_THRESHOLD;
         thr[2] <= `RST_THRESHOLD;
         status <= 6'h0;
         irq_en <= 6'h0;
         interrupt_out <= 1'b0;
         event_n <= 1'b1;
      end
      else if (ce)
      begin
         wr_pend <= addr_ok & hwrite;
         if (addr_ok)
            wr_addr <= haddr;
         if (addr_ok && !hwrite)
            hrdata <= rd_mux;
         if (wr_pend)
         begin
            if (wr_addr == `OFS_EP_CONFIG)
            begin
               run_en <= hwdata[`CFG_RUN_BIT];
               ld_accum <= hwdata[`CFG_LD_ACCUM_BIT];
               tmr_mode <= hwdata[`CFG_TMR_MODE_BIT];
               noload_window_sel <= hwdata[`CFG_NL_SEL_LSB +: 3];
               event_sel <= hwdata[`CFG_EVENT_SEL_BIT];
            end
            else if (wr_addr == `OFS_ENERGY_TIME)
               energy_interval_count <= hwdata[12:0];
            else if (wr_addr == `OFS_POWER_TIME)
               power_interval_count <= hwdata[12:0];
            else if (wr_addr == `OFS_ACC_MODE)
            begin
               active_accum_mode <= hwdata[`MODE_ACT_LSB +: 2];
               reactive_accum_mode <= hwdata[`MODE_REACT_LSB +: 2];
               line_freq_select <= hwdata[`MODE_FREQ_BIT];
            end
            else if (wr_addr == `OFS_ACT_THR)
               thr[0] <= hwdata;
            else if (wr_addr == `OFS_REACT_THR)
               thr[1] <= hwdata;
            else if (wr_addr == `OFS_APP_THR)
               thr[2] <= hwdata;
            else if (wr_addr == `OFS_IRQ_ENABLE)
               irq_en <= hwdata[5:0];
         end
         // write one to clear; a change in the same cycle stays set
         status <= (status & ~((wr_pend && wr_addr == `OFS_STATUS)
                    ? hwdata[5:0] : 6'h0))
                   | ((state == S_IDLE) ? chg : 6'h0);
         interrupt_out <= |(status & irq_en);
         event_n <= ~(event_sel & (|nl_flag));
      end
   end
endmodule // energy_accum_noload

/* test/energy_accum_asserts.sv */
// checker: bus answer and event relations of the accumulation block
// assumes it is bound to the top module and sees its ports only
`timescale 1ns/1ps
module energy_accum_asserts (
   // clock and reset
   input logic       hclk,
   input logic       hresetn,
   // bus side
   input logic       hsel,
   input logic [1:0] htrans,
   input logic       hready,
   input logic       hreadyout,
   input logic       hresp,
   // events
   input logic       sample_strobe,
   input logic       half_cycle_pulse,
   input logic       pf_update,
   input logic       interrupt_out,
   input logic       event_n,
   input logic       rms_half_update,
   input logic       rms_multi_update
);
   logic [7:0] since; // cycles since the last sample, saturating

   ////////////////////////////////////////////////////////////////////
   // age of the last sample; a sweep lasts under 40 cycles
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         since <= 8'hFF;
      else if (sample_strobe)
         since <= 8'h00;
      else if (since != 8'hFF)
         since <= since + 8'h01;
   end

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_taken;
      hsel && htrans[1] && hready;
   endsequence
   sequence s_answer;
      hreadyout && !hresp ##1 hreadyout;
   endsequence

   AST_ZERO_WAIT: assert property (s_taken |=> s_answer)
      else $error("bus answer not zero wait");
   AST_OKAY: assert property (s_taken |=> !hresp)
      else $error("bus response not okay");
   AST_HALF_CAUSE: assert property (rms_half_update |-> $past(half_cycle_pulse))
      else $error("half rms update without half cycle");
   AST_HALF_PULSE: assert property (rms_half_update |=> !rms_half_update)
      else $error("half rms update too long");
   AST_MULTI_PULSE: assert property ($rose(rms_multi_update) |=> !rms_multi_update)
      else $error("multi rms update too long");
   AST_IRQ_CAUSE: assert property ($rose(interrupt_out) |-> since < 8'h3C)
      else $error("interrupt rose with no window end");
   // a clear is taken three edges before the output is seen low
   AST_IRQ_HOLD: assert property ($fell(interrupt_out) |-> $past(hsel && htrans[1], 3))
      else $error("interrupt fell without bus access");
   AST_EVENT_CAUSE: assert property ($fell(event_n) |-> since < 8'h3C)
      else $error("event pin fell with no window end");
   AST_PF_CAUSE: assert property (pf_update |-> $past(sample_strobe))
      else $error("power factor strobe without a sample");
   AST_PF_PULSE: assert property (pf_update |=> !pf_update)
      else $error("power factor strobe too long");
endmodule // energy_accum_asserts

bind energy_accum_noload energy_accum_asserts chk_i (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .sample_strobe(sample_strobe), .half_cycle_pulse(half_cycle_pulse),
   .pf_update(pf_update),
   .interrupt_out(interrupt_out), .event_n(event_n),
   .rms_half_update(rms_half_update), .rms_multi_update(rms_multi_update)
);

/* test/tb_energy_accum_noload.sv */
// testbench: registers, accumulation modes, no-load and rms strobes
// assumes a zero-wait slave; one sample value feeds all channels
`timescale 1ns/1ps
module tb_energy_accum_noload;
   logic        hclk = 1'b0;          // 125 MHz bus clock
   logic        hresetn = 1'b0;       // async reset, active low
   logic        hsel = 1'b0;          // bus select
   logic [11:0] haddr = 12'h000;      // bus address
   logic [1:0]  htrans = 2'h0;        // idle or nonseq
   logic        hwrite = 1'b0;        // write flag
   logic [31:0] hwdata = 32'h0;       // write data
   logic        sample_strobe = 1'b0; // new sample
   logic        half_cycle_pulse = 1'b0;
   logic [95:0] pw = 96'h0;           // sample on every phase
   logic [31:0] q;                    // last read data
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, interrupt_out, event_n;
   wire         rms_half_update, rms_multi_update, pf_update;
   int          n_mismatch = 0, checks = 0, n_half = 0, n_multi = 0;
   int          n_pf = 0;             // power factor strobes seen
   // expected words of phase a for modes 0..3 with a -100 sample
   logic [31:0] elo [4] = '{32'h1F9C, 32'h0064, 32'h0, 32'h1F9C};
   logic [31:0] ehi [4] = '{32'hFFFFFFFF, 32'h0, 32'h0, 32'hFFFFFFFF};

   energy_accum_noload dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .sample_strobe(sample_strobe), .half_cycle_pulse(half_cycle_pulse),
      .active_power(pw), .reactive_power(pw), .apparent_power(pw),
      .fund_active_power(pw), .fund_reactive_power(pw),
      .fund_apparent_power(pw), .interrupt_out(interrupt_out),
      .event_n(event_n), .pf_update(pf_update),
      .rms_half_update(rms_half_update),
      .rms_multi_update(rms_multi_update));

   ////////////////////////////////////////////////////////////////////
   always #4 hclk = ~hclk;
   // strobe counters, read back by the rms and no-load scenarios
   always @(posedge hclk) n_half <= n_half + rms_half_update;
   always @(posedge hclk) n_multi <= n_multi + rms_multi_update;
   always @(posedge hclk) n_pf <= n_pf + pf_update;

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // one single transfer; the wait loops end only on hready
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   // strobes are kept 41 cycles apart, above the sweep length
   task smp(input logic [31:0] p);
      pw <= {3{p}};
      sample_strobe <= 1'b1;
      @(posedge hclk);
      sample_strobe <= 1'b0;
      repeat (40) @(posedge hclk);
   endtask

   ////////////////////////////////////////////////////////////////////
   task t_reset;
      rd(12'h000, 32'h0);
      rd(12'h008, 32'h1FFF);
      rd(12'h018, 32'h6778);
      rd(12'h040, 32'h0);
   endtask
   task t_modes;
      bus(1'b1, 12'h000, 32'h3);
      for (int t = 0; t < 2; t++)
         for (int m = 0; m < 4; m++)
         begin
            bus(1'b1, 12'h00C, 32'(m) << (2 * t));
            smp(32'hFFFFFF9C);
            rd(12'h104 + 12'(t * 24), elo[m]);
            rd(12'h100 + 12'(t * 24), ehi[m]);
         end
      bus(1'b1, 12'h00C, 32'h0);
      bus(1'b1, 12'h000, 32'h1);
      smp(32'hFFFFFF9C);
      rd(12'h11C, 32'h1F38);
   endtask
   // run off clears the half cycle count; then n pulses at 50 or 60 hz
   task t_rms(input logic f, input int n, input int e);
      int h0, m0;
      bus(1'b1, 12'h000, 32'h0);
      bus(1'b1, 12'h00C, {27'h0, f, 4'h0});
      bus(1'b1, 12'h000, 32'h1);
      h0 = n_half;
      m0 = n_multi;
      repeat (n)
      begin
         half_cycle_pulse <= 1'b1;
         @(posedge hclk);
         half_cycle_pulse <= 1'b0;
         repeat (2) @(posedge hclk);
      end
      chk(n_half - h0, n);
      chk(n_multi - m0, e);
   endtask
   task t_noload;
      bus(1'b1, 12'h000, 32'h0);
      for (int i = 0; i < 3; i++)
         bus(1'b1, 12'h010 + 12'(4 * i), 32'h7FFFFFFF);
      bus(1'b1, 12'h024, 32'h1);
      bus(1'b1, 12'h008, 32'h0);
      bus(1'b1, 12'h000, 32'h103);
      repeat (64) smp(32'd100);
      rd(12'h01C, 32'h01FF01FF);
      rd(12'h020, 32'h3F);
      chk(interrupt_out, 1'b1);
      chk(event_n, 1'b0);
      smp(32'h40000);
      rd(12'h104, 32'h0);
      rd(12'h100, 32'h0);
      rd(12'h200, 32'h20);
      bus(1'b1, 12'h020, 32'h3F);
      repeat (3) @(posedge hclk);
      chk(interrupt_out, 1'b0);
      bus(1'b1, 12'h000, 32'h173);
      smp(32'd100);
      rd(12'h01C, 32'h0);
      rd(12'h104, 32'h64);
      chk(n_pf, 32'h0);
   endtask

   ////////////////////////////////////////////////////////////////////
   task close_out;
      $display("checks %0d, mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // the tests need under 6000 cycles; a hang ends at 20000
   initial
   begin
      #160000;
      n_mismatch++;
      close_out;
   end
   initial
   begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset;
      t_modes;
      t_rms(1'b0, 24, 1);
      t_rms(1'b1, 23, 0);
      t_noload;
      close_out;
   end
endmodule // tb_energy_accum_noload
